/* File: bench/ccp_testbench.sv */
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------------
   // Stimulus and design
   // ---------------------------------------------------------------
   logic        clk          = 1'b0;
   logic        rst          = 1'b1;
   logic        psel         = 1'b0;
   logic        penable      = 1'b0;
   logic        pwrite       = 1'b0;
   logic [7:0]  paddr        = 8'h00;
   logic [31:0] pwdata       = 32'h0;
   logic        main_osc_clk = 1'b0;
   logic        ring_osc_clk = 1'b0;
   logic        wait_exec    = 1'b0;
   logic        int_wake_irq = 1'b0;
   logic        ext_wake_irq = 1'b0;
   logic        main_run     = 1'b1;
   logic [31:0] prdata;
   logic        pready, pslverr, cpu_clk, converter_clock, ring_periph_clock;
   logic        ring_derived_slow_clock, main_osc_enable, ring_osc_enable;
   logic        osc_drive_high, pin_hold, main_stop_detected;
   logic [3:0]  timer_clk;
   logic [2:0]  serial_clk;
   logic [10:0] mon;
   int          mcnt = 0;
   int          rcnt = 0;
   int          miscompares = 0;
   int          n_tests = 0;

   always #12.5 clk = ~clk;

   // Oscillators only run while enabled, so a stop really starves the block
   always @(posedge clk) begin
      mcnt <= (mcnt == 2) ? 0 : mcnt + 1;
      rcnt <= (rcnt == 4) ? 0 : rcnt + 1;
      if (mcnt == 2 && main_run && main_osc_enable === 1'b1) main_osc_clk <= ~main_osc_clk;
      if (rcnt == 4 && ring_osc_enable === 1'b1) ring_osc_clk <= ~ring_osc_clk;
   end

   assign mon = {converter_clock, ring_derived_slow_clock, ring_periph_clock,
                 serial_clk, timer_clk, cpu_clk};

   ccp_clock_ctrl u_ccp_clock_ctrl (.clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .main_osc_clk, .ring_osc_clk, .wait_exec,
      .int_wake_irq, .ext_wake_irq, .cpu_clk, .timer_clk, .serial_clk,
      .converter_clock, .ring_periph_clock, .ring_derived_slow_clock,
      .main_osc_enable, .ring_osc_enable, .osc_drive_high, .pin_hold,
      .main_stop_detected);

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Look between edges, where the answer has settled
      @(negedge clk);
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(negedge clk);
      if (n == 20) begin
         miscompares++;
         close_out();
      end
      q = prdata;
      e = pslverr;
      // Request stands through the edge that samples pready high
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      `CHK(q, x)
   endtask

   function automatic logic [31:0] st(input int r, input int s, input int m);
      return 32'(r * 8 + s * 4 + m);
   endfunction

   // Period of the third rise, so a pending ratio change has landed
   task automatic per(input int i, input int x);
      int   n, r, c;
      logic p;
      p = mon[i];
      r = 0;
      c = 0;
      for (n = 0; n < 6000 && r < 3; n++) begin
         @(posedge clk);
         if (r == 2) c++;
         if (mon[i] === 1'b1 && p !== 1'b1) r++;
         p = mon[i];
      end
      if (r < 3) begin
         miscompares++;
         close_out();
      end
      `CHK(c, x)
   endtask

   task automatic togs(input int i, output int t);
      logic p;
      t = 0;
      p = mon[i];
      repeat (40) begin
         @(posedge clk);
         if (mon[i] !== p) t++;
         p = mon[i];
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] q;
      logic        e;
      // Reserved bits are not stored, so they read as zero
      rdc(ccp_pkg::OFS_CTRL0, ccp_pkg::RST_CTRL0 & 32'h64);
      rdc(ccp_pkg::OFS_CTRL1, ccp_pkg::RST_CTRL1);
      rdc(ccp_pkg::OFS_SRC, ccp_pkg::RST_SRC);
      wr(ccp_pkg::OFS_STATUS, 32'hff);
      rdc(ccp_pkg::OFS_STATUS, st(8, 1, 0));
      apb(1'b0, 8'h10, 32'h0, q, e);
      `CHK({e, q}, 33'h1_0000_0000)
      per(0, 80);
      per(8, 10);
      per(9, 1280);
   endtask

   task automatic t_main();
      int tp[7] = '{1, 2, 8, 32, 1, 8, 32};
      int r;
      wr(ccp_pkg::OFS_CTRL0, 32'h40);
      repeat (20) @(posedge clk);
      wr(ccp_pkg::OFS_SRC, 32'h00);
      per(0, 48);
      for (int c = 0; c < 4; c++) begin
         r = (c == 3) ? 16 : (1 << c);
         wr(ccp_pkg::OFS_CTRL1, 32'h20 | (32'(c) << 6));
         wr(ccp_pkg::OFS_CTRL0, 32'h00);
         per(0, 6 * r);
         rdc(ccp_pkg::OFS_STATUS, st(r, 0, 0));
      end
      wr(ccp_pkg::OFS_CTRL0, 32'h40);
      per(0, 48);
      for (int i = 0; i < 7; i++) per(i + 1, 6 * tp[i]);
      per(10, 6);
   endtask

   task automatic t_wait(input logic off);
      int t;
      wr(ccp_pkg::OFS_CTRL1, 32'h20);
      wr(ccp_pkg::OFS_CTRL0, off ? 32'h04 : 32'h00);
      // Let the new ratio land before the clock freezes
      per(0, 6);
      @(posedge clk) wait_exec <= 1'b1;
      @(posedge clk) wait_exec <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(ccp_pkg::OFS_STATUS, st(1, 0, 1));
      `CHK(pin_hold, 1'b1)
      togs(0, t);
      `CHK(t, 0)
      `CHK({main_osc_enable, ring_osc_enable}, 2'b11)
      togs(1, t);
      `CHK(t == 0, off)
      togs(8, t);
      `CHK(t > 0, 1'b1)
      int_wake_irq <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(ccp_pkg::OFS_STATUS, st(1, 0, off));
      @(posedge clk);
      ext_wake_irq <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(ccp_pkg::OFS_STATUS, st(1, 0, 0));
      @(posedge clk);
      int_wake_irq <= 1'b0;
      ext_wake_irq <= 1'b0;
      `CHK(pin_hold, 1'b0)
      per(0, 6);
   endtask

   task automatic t_stop();
      logic [31:0] q;
      logic        e;
      int          t;
      wr(ccp_pkg::OFS_CTRL1, 32'h00);
      `CHK(osc_drive_high, 1'b0)
      wr(ccp_pkg::OFS_CTRL1, 32'h01);
      repeat (3) @(posedge clk);
      apb(1'b0, ccp_pkg::OFS_STATUS, 32'h0, q, e);
      `CHK(q[1:0], 2'h2)
      `CHK({main_osc_enable, ring_osc_enable, osc_drive_high}, 3'b001)
      rdc(ccp_pkg::OFS_CTRL0, 32'h40);
      togs(0, t);
      `CHK(t, 0)
      togs(10, t);
      `CHK(t, 0)
      int_wake_irq <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, ccp_pkg::OFS_STATUS, 32'h0, q, e);
      `CHK(q[1:0], 2'h2)
      @(posedge clk);
      ext_wake_irq <= 1'b1;
      repeat (3) @(posedge clk);
      int_wake_irq <= 1'b0;
      ext_wake_irq <= 1'b0;
      per(0, 48);
      rdc(ccp_pkg::OFS_STATUS, st(8, 0, 0));
   endtask

   task automatic t_detect();
      int n;
      wr(ccp_pkg::OFS_SRC, 32'h03);
      main_run <= 1'b0;
      for (n = 0; n < 200 && main_stop_detected !== 1'b1; n++) @(posedge clk);
      `CHK(main_stop_detected, 1'b1)
      rdc(ccp_pkg::OFS_SRC, 32'h0f);
      per(0, 80);
   endtask

   // No wake source is raised, so only a reset may end the mode
   task automatic t_hw_exit(input logic stop);
      if (stop) begin
         wr(ccp_pkg::OFS_SRC, 32'h04);
         wr(ccp_pkg::OFS_CTRL1, 32'h01);
      end else begin
         @(posedge clk) wait_exec <= 1'b1;
         @(posedge clk) wait_exec <= 1'b0;
      end
      repeat (40) @(posedge clk);
      `CHK(pin_hold, 1'b1)
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(ccp_pkg::OFS_STATUS, st(8, 1, 0));
      `CHK(pin_hold, 1'b0)
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_main();
      t_wait(1'b1);
      t_wait(1'b0);
      wr(ccp_pkg::OFS_SRC, 32'h00);
      t_stop();
      t_detect();
      t_hw_exit(1'b0);
      t_hw_exit(1'b1);
      close_out();
   end
endmodule // testbench

/* File: logic/ccp_clock_ctrl.sv */
// How it works
// - After reset the CPU clock is the ring clock divided by eight.
// - Source select 0 picks the main clock; software waits for stable main.
// - Detect enabled 11 and main stopped: fall over to ring clock.
// - Divider codes give 1, 2, 4, 16; fixed div8 bit forces eight.
// - Writing all-clock-stop enters stop, sets div8 and drive high.
// - Timer clocks divide by 1,2,8,32; serial by 1,8,32.
// - Ring clock out at ring rate, plus that divided by 128.
// - Wait with peripheral-off bit gates timer, serial, converter clocks.
// - Ring clock and its slow clock keep running in wait.
// - Wait stops the CPU clock; both oscillators keep running.
// - Medium speed: main clock divided by 2, 4, 8 or 16.
// - Wait instruction enters wait; pins hold their state meanwhile.
// - Wake from wait restores the CPU clock used before.
// - Peripheral-off bit set: only externally clocked interrupts wake wait.
// - Stop turns off oscillators, CPU and peripheral clocks.
// - Only externally clocked wake sources end stop mode.
// - Stop wake runs the CPU from the prior source divided by eight.
module ccp_clock_ctrl (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        main_osc_clk,
   input  wire logic        ring_osc_clk,
   input  wire logic        wait_exec,
   input  wire logic        int_wake_irq,
   input  wire logic        ext_wake_irq,
   output logic             cpu_clk,
   output logic [3:0]       timer_clk,
   output logic [2:0]       serial_clk,
   output logic             converter_clock,
   output logic             ring_periph_clock,
   output logic             ring_derived_slow_clock,
   output logic             main_osc_enable,
   output logic             ring_osc_enable,
   output logic             osc_drive_high,
   output logic             pin_hold,
   output logic             main_stop_detected
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      ccp_pkg::ccp_mode_t mode;
      logic        wait_off;
      logic        main_off;
      logic        div8;
      logic        all_stop;
      logic        drive_hi;
      logic [1:0]  div_sel;
      logic [1:0]  osd;
      logic        src_sel;
      logic        main_stop;
      logic        act_src;
      logic [4:0]  act_ratio;
      logic [4:0]  ccnt;
      logic        cpu_clk;
      logic [5:0]  pcnt;
      logic        adc;
      logic [7:0]  rcnt;
      logic [5:0]  mcnt;
      logic        main_en;
      logic        ring_en;
      logic        hold;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ccp_state_t;

   ccp_state_t st;
   ccp_state_t next_st;
   ccp_edge_if e ();

   logic       wr;
   logic       src_e;
   logic       lost;
   logic       wake;

   ccp_osc_sync u_sync (
      .clk          (clk),
      .rst          (rst),
      .main_osc_clk (main_osc_clk),
      .ring_osc_clk (ring_osc_clk),
      .e            (e)
   );

   // Fixed div8 overrides the two divider bits
   function automatic logic [4:0] ratio_of(input logic d8, input logic [1:0] sel);
      logic [4:0] r;
      r = ccp_pkg::RATIO_1;
      if (d8) begin
         r = ccp_pkg::RATIO_8;
      end else if (sel == 2'h1) begin
         r = ccp_pkg::RATIO_2;
      end else if (sel == 2'h2) begin
         r = ccp_pkg::RATIO_4;
      end else if (sel == 2'h3) begin
         r = ccp_pkg::RATIO_16;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      wr = psel & penable & st.pready & pwrite;
      src_e = st.act_src ? e.ring_edge : e.main_edge;

      // Bus: answer in the first access cycle
      next_st.pready = psel & ~penable;
      next_st.pslverr = 1'b0;
      if (psel & ~penable) begin
         next_st.prdata = '0;
         if (paddr == ccp_pkg::OFS_CTRL0) begin
            next_st.prdata[ccp_pkg::BIT_WAIT_OFF] = st.wait_off;
            next_st.prdata[ccp_pkg::BIT_MAIN_OFF] = st.main_off;
            next_st.prdata[ccp_pkg::BIT_DIV8] = st.div8;
         end else if (paddr == ccp_pkg::OFS_CTRL1) begin
            next_st.prdata[ccp_pkg::BIT_ALL_STOP] = st.all_stop;
            next_st.prdata[ccp_pkg::BIT_DRIVE_HI] = st.drive_hi;
            next_st.prdata[ccp_pkg::BIT_DIV_HI:ccp_pkg::BIT_DIV_LO] = st.div_sel;
         end else if (paddr == ccp_pkg::OFS_SRC) begin
            next_st.prdata[ccp_pkg::BIT_OSD_HI:ccp_pkg::BIT_OSD_LO] = st.osd;
            next_st.prdata[ccp_pkg::BIT_SRC_SEL] = st.src_sel;
            next_st.prdata[ccp_pkg::BIT_MAIN_STOP] = st.main_stop;
         end else if (paddr == ccp_pkg::OFS_STATUS) begin
            next_st.prdata[7:0] = {st.act_ratio, st.act_src, st.mode};
         end else begin
            next_st.pslverr = 1'b1;
         end
      end

      // Register writes; ignored while the CPU is not running
      if (wr && st.mode == ccp_pkg::MODE_RUN) begin
         if (paddr == ccp_pkg::OFS_CTRL0) begin
            next_st.wait_off = pwdata[ccp_pkg::BIT_WAIT_OFF];
            next_st.main_off = pwdata[ccp_pkg::BIT_MAIN_OFF];
            next_st.div8 = pwdata[ccp_pkg::BIT_DIV8];
         end else if (paddr == ccp_pkg::OFS_CTRL1) begin
            next_st.drive_hi = pwdata[ccp_pkg::BIT_DRIVE_HI];
            next_st.div_sel = pwdata[ccp_pkg::BIT_DIV_HI:ccp_pkg::BIT_DIV_LO];
            if (pwdata[ccp_pkg::BIT_ALL_STOP]) begin
               next_st.all_stop = 1'b1;
               next_st.mode = ccp_pkg::MODE_STOP;
               next_st.div8 = 1'b1;
               next_st.drive_hi = 1'b1;
            end
         end else if (paddr == ccp_pkg::OFS_SRC) begin
            next_st.osd = pwdata[ccp_pkg::BIT_OSD_HI:ccp_pkg::BIT_OSD_LO];
            next_st.src_sel = pwdata[ccp_pkg::BIT_SRC_SEL];
            if (!pwdata[ccp_pkg::BIT_MAIN_STOP]) begin
               next_st.main_stop = 1'b0;
            end
         end
      end

      // ------------------------------------------------------------
      // Main oscillator loss watch
      // ------------------------------------------------------------
      if (e.main_edge) begin
         next_st.mcnt = '0;
      end else if (st.mcnt != ccp_pkg::MAIN_TO_CYC) begin
         next_st.mcnt = st.mcnt + 6'h01;
      end
      lost = !e.main_edge && st.mcnt == ccp_pkg::MAIN_TO_CYC - 6'h01
             && st.osd == ccp_pkg::OSD_ON && st.act_src == ccp_pkg::SRC_MAIN
             && st.mode == ccp_pkg::MODE_RUN;
      if (lost) begin
         // Set wins over a clearing write in the same cycle
         next_st.src_sel = ccp_pkg::SRC_RING;
         next_st.main_stop = 1'b1;
      end

      // ------------------------------------------------------------
      // Power modes
      // ------------------------------------------------------------
      wake = ext_wake_irq | (int_wake_irq & ~st.wait_off);
      if (st.mode == ccp_pkg::MODE_RUN && wait_exec && !next_st.all_stop) begin
         next_st.mode = ccp_pkg::MODE_WAIT;
      end else if (st.mode == ccp_pkg::MODE_WAIT && wake) begin
         next_st.mode = ccp_pkg::MODE_RUN;
      end else if (st.mode == ccp_pkg::MODE_STOP && ext_wake_irq) begin
         next_st.mode = ccp_pkg::MODE_RUN;
         next_st.all_stop = 1'b0;
         if (!st.cpu_clk) begin
            next_st.act_src = st.src_sel;
            next_st.act_ratio = ccp_pkg::RATIO_8;
            next_st.ccnt = '0;
         end
      end
      next_st.hold = next_st.mode != ccp_pkg::MODE_RUN;
      next_st.main_en = !next_st.main_off && next_st.mode != ccp_pkg::MODE_STOP;
      // Ring never stops outside stop, so a lost main always has a fallback
      next_st.ring_en = next_st.mode != ccp_pkg::MODE_STOP;

      // ------------------------------------------------------------
      // CPU clock divider
      // ------------------------------------------------------------
      // Outside run only the high phase may finish, so no runt pulse
      if (lost) begin
         // Main is silent, so the current phase, high or low, is simply restarted on ring
         next_st.act_src = ccp_pkg::SRC_RING;
         next_st.ccnt = '0;
      end else if ((st.mode == ccp_pkg::MODE_RUN || st.cpu_clk) && src_e) begin
         if (st.ccnt == st.act_ratio - 5'h01) begin
            next_st.ccnt = '0;
            next_st.cpu_clk = ~st.cpu_clk;
            if (st.cpu_clk) begin
               // New setting only from a falling edge on
               next_st.act_src = next_st.src_sel;
               next_st.act_ratio = ratio_of(next_st.div8, next_st.div_sel);
            end
         end else begin
            next_st.ccnt = st.ccnt + 5'h01;
         end
      end else if (st.mode != ccp_pkg::MODE_RUN) begin
         next_st.ccnt = '0;
      end

      // ------------------------------------------------------------
      // Peripheral clocks
      // ------------------------------------------------------------
      if (st.mode == ccp_pkg::MODE_STOP
          || (st.mode == ccp_pkg::MODE_WAIT && st.wait_off)) begin
         next_st.pcnt = '0;
         next_st.adc = 1'b0;
      end else begin
         if (src_e) begin
            next_st.pcnt = st.pcnt + 6'h01;
         end
         if (e.main_edge) begin
            next_st.adc = ~st.adc;
         end
      end
      if (st.mode == ccp_pkg::MODE_STOP) begin
         next_st.rcnt = '0;
      end else if (e.ring_edge) begin
         next_st.rcnt = st.rcnt + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.mode <= ccp_pkg::MODE_RUN;
         st.wait_off <= ccp_pkg::RST_CTRL0[ccp_pkg::BIT_WAIT_OFF];
         st.main_off <= ccp_pkg::RST_CTRL0[ccp_pkg::BIT_MAIN_OFF];
         st.div8 <= ccp_pkg::RST_CTRL0[ccp_pkg::BIT_DIV8];
         st.drive_hi <= ccp_pkg::RST_CTRL1[ccp_pkg::BIT_DRIVE_HI];
         st.src_sel <= ccp_pkg::RST_SRC[ccp_pkg::BIT_SRC_SEL];
         st.act_src <= ccp_pkg::SRC_RING;
         st.act_ratio <= ccp_pkg::RATIO_8;
         st.ring_en <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from state
   // ---------------------------------------------------------------
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign cpu_clk = st.cpu_clk;
   assign timer_clk = {st.pcnt[5], st.pcnt[3], st.pcnt[1], st.pcnt[0]};
   assign serial_clk = {st.pcnt[5], st.pcnt[3], st.pcnt[0]};
   assign converter_clock = st.adc;
   assign ring_periph_clock = st.rcnt[0];
   assign ring_derived_slow_clock = st.rcnt[7];
   assign main_osc_enable = st.main_en;
   assign ring_osc_enable = st.ring_en;
   assign osc_drive_high = st.drive_hi;
   assign pin_hold = st.hold;
   assign main_stop_detected = st.main_stop;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   reset_ring_a: assert property ($fell(rst) |->
      st.act_src == ccp_pkg::SRC_RING && st.act_ratio == ccp_pkg::RATIO_8)
      else $error("reset clock not ring div8");
   src_load_a: assert property (st.cpu_clk && src_e && !lost
      && st.ccnt == st.act_ratio - 5'h01 |=> st.act_src == $past(next_st.src_sel))
      else $error("source not loaded at fall");
   osc_loss_a: assert property (lost |=>
      st.act_src == ccp_pkg::SRC_RING && st.main_stop && st.src_sel)
      else $error("main loss not handled");
   div_ratio_a: assert property (st.cpu_clk && src_e && !lost && next_st.div8
      && st.ccnt == st.act_ratio - 5'h01 |=> st.act_ratio == ccp_pkg::RATIO_8)
      else $error("div8 not honoured");
   stop_entry_a: assert property (st.mode == ccp_pkg::MODE_RUN && wr
      && paddr == ccp_pkg::OFS_CTRL1 && pwdata[ccp_pkg::BIT_ALL_STOP]
      |=> st.mode == ccp_pkg::MODE_STOP && st.div8 && st.drive_hi ##1 !st.ring_en)
      else $error("stop entry incomplete");
   wait_gate_a: assert property (st.mode == ccp_pkg::MODE_WAIT && st.wait_off
      |=> st.pcnt == 6'h00 && !st.adc)
      else $error("wait gating failed");
   ring_run_a: assert property (st.mode == ccp_pkg::MODE_WAIT && e.ring_edge
      |=> st.rcnt == $past(st.rcnt) + 8'h01)
      else $error("ring clock halted in wait");
   wait_cpu_a: assert property (st.mode == ccp_pkg::MODE_WAIT
      && !st.cpu_clk |=> !st.cpu_clk && st.ring_en)
      else $error("cpu clock ran in wait");
   wait_wake_a: assert property (st.mode == ccp_pkg::MODE_WAIT && st.wait_off
      && !ext_wake_irq |=> st.mode == ccp_pkg::MODE_WAIT)
      else $error("wait left by gated source");
   stop_wake_a: assert property (st.mode == ccp_pkg::MODE_STOP && !ext_wake_irq
      |=> st.mode == ccp_pkg::MODE_STOP)
      else $error("stop left without wake");

   wait_cycle_c: cover property (st.mode == ccp_pkg::MODE_WAIT ##[1:50]
      st.mode == ccp_pkg::MODE_RUN);
   stop_cycle_c: cover property (st.mode == ccp_pkg::MODE_STOP ##[1:50]
      st.mode == ccp_pkg::MODE_RUN);
   loss_c: cover property (lost);

endmodule // ccp_clock_ctrl

/* File: logic/ccp_edge_if.sv */
interface ccp_edge_if;
   logic main_edge;
   logic ring_edge;
   modport src (output main_edge, output ring_edge);
   modport snk (input main_edge, input ring_edge);
endinterface

/* File: logic/ccp_osc_sync.sv */
module ccp_osc_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic main_osc_clk,
   input  wire logic ring_osc_clk,
   ccp_edge_if.src   e
);

   typedef struct packed {
      logic [2:0] m;
      logic [2:0] r;
   } ccp_sync_t;

   ccp_sync_t st;
   ccp_sync_t next_st;

   always_comb begin
      next_st   = st;
      next_st.m = {st.m[1:0], main_osc_clk};
      next_st.r = {st.r[1:0], ring_osc_clk};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Both edges count: each one is half a source period
   assign e.main_edge = st.m[2] ^ st.m[1];
   assign e.ring_edge = st.r[2] ^ st.r[1];

endmodule // ccp_osc_sync

/* File: logic/ccp_pkg.sv */
package ccp_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL0  = 8'h00;
   localparam logic [7:0] OFS_CTRL1  = 8'h04;
   localparam logic [7:0] OFS_SRC    = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_WAIT_OFF  = 2;
   localparam int BIT_MAIN_OFF  = 5;
   localparam int BIT_DIV8      = 6;
   localparam int BIT_ALL_STOP  = 0;
   localparam int BIT_DRIVE_HI  = 5;
   localparam int BIT_DIV_LO    = 6;
   localparam int BIT_DIV_HI    = 7;
   localparam int BIT_OSD_LO    = 0;
   localparam int BIT_OSD_HI    = 1;
   localparam int BIT_SRC_SEL   = 2;
   localparam int BIT_MAIN_STOP = 3;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_CTRL0 = 32'h0000_0068;
   localparam logic [31:0] RST_CTRL1 = 32'h0000_0020;
   localparam logic [31:0] RST_SRC   = 32'h0000_0004;

   // ---------------------------------------------------------------
   // Clock source, ratios and timing
   // ---------------------------------------------------------------
   localparam logic       SRC_MAIN  = 1'b0;
   localparam logic       SRC_RING  = 1'b1;
   localparam logic [4:0] RATIO_1   = 5'h01;
   localparam logic [4:0] RATIO_2   = 5'h02;
   localparam logic [4:0] RATIO_4   = 5'h04;
   localparam logic [4:0] RATIO_8   = 5'h08;
   localparam logic [4:0] RATIO_16  = 5'h10;
   localparam logic [1:0] OSD_ON    = 2'h3;
   localparam int CLK_PERIOD_NS = 25;
   localparam int MAIN_TO_NS    = 1000;
   localparam logic [5:0] MAIN_TO_CYC =
      6'((MAIN_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      MODE_RUN  = 2'b00,
      MODE_WAIT = 2'b01,
      MODE_STOP = 2'b10
   } ccp_mode_t;

endpackage
